// ===== inc/baud_pkg.sv
// Constants for the serial bit-rate generator: register indices, field positions,
// reset values and divide ratios.
// Assumes a single core clock; the register file sits behind an Avalon-MM slave.
package baud_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SERIAL_MODE = 8'h10;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h11;
  localparam logic [7:0] IDX_TIMER_MODE = 8'h12;
  localparam logic [7:0] IDX_T1_RELOAD = 8'h13;
  localparam logic [7:0] IDX_T2_CONTROL = 8'h14;
  localparam logic [7:0] IDX_T2_RELOAD_LOW = 8'h15;
  localparam logic [7:0] IDX_T2_RELOAD_HIGH = 8'h16;
  localparam logic [7:0] IDX_STATUS = 8'h17;
  localparam logic [7:0] IDX_FRACTIONAL_DIV = 8'h9D;
  localparam logic [7:0] IDX_DEDICATED_CTRL = 8'h9E;
  // Field positions
  localparam int SERIAL_MODE_A_BIT = 7;
  localparam int SERIAL_MODE_B_BIT = 6;
  localparam int DOUBLE_RATE_BIT = 7;
  localparam int T2_RX_SELECT_BIT = 5;
  localparam int T2_TX_SELECT_BIT = 4;
  localparam int DEDICATED_EN_BIT = 7;
  localparam int DIV_CODE_MSB = 2;
  localparam int FRAC_MSB = 5;
  // Reset value and largest divider code
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] DIV_CODE_MAX = 3'h6;
  // Timer 1 upper mode nibble for 8-bit autoreload timer
  localparam logic [3:0] T1_AUTORELOAD_NIBBLE = 4'h2;
  // Divide ratios
  localparam int unsigned SHIFT_MODE_DIV = 12;
  localparam int unsigned FIXED_BASE_DIV = 16;
  localparam int unsigned OVERFLOWS_PER_BIT = 16;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam logic [7:0] FRAC_OFFSET = 8'h40;
  // Decoded serial mode, one-hot
  typedef enum logic [3:0] {
    MODE_SHIFT = 4'b0001,
    MODE_VAR8 = 4'b0010,
    MODE_FIX9 = 4'b0100,
    MODE_VAR9 = 4'b1000
  } serial_mode_t;
endpackage

// ===== design/rate_divider.sv
// Enable divider: one tick for every N enable pulses.
// Assumes en is a one-cycle pulse on ref_clk.
`timescale 1ns/1ns
module rate_divider #(
  parameter int unsigned N = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Enable in, tick out
  input wire logic en,
  output logic tick
);
  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST = W'(N - 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb
  begin
    next_count = count;
    tick = 1'b0;
    if (en)
    begin
      if (count == LAST)
      begin
        next_count = '0;
        tick = 1'b1;
      end
      else
      begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else
      count <= next_count;
  end
endmodule

// ===== design/uart_baud_rate_generator.sv
// Bit-rate tick generator for the serial port, with its configuration registers.
// Assumes the shift logic consumes one-cycle bit ticks on ref_clk and an
// external Timer 1 delivers overflow pulses on the same clock when not in autoreload.
// Function
// - Shift-register mode bit rate is core clock divided by twelve.
// - Fixed nine-bit mode: core clock over 32, or over 16 with double rate.
// - Variable modes use Timer 1 or Timer 2 overflow, per direction.
// - Timer 1 rate: overflow rate times two-to-double-rate over 32.
// - Timer 1 autoreload nibble 0010: core clock over 256 minus reload byte.
// - Timer 2 source: sixteen overflows per bit.
// - In generator mode Timer 2 advances every two core clocks.
// - Transmit/receive select bits put Timer 2 in generator mode per direction.
// - Timer 2 reloads from its 16-bit reload pair on overflow.
// - Dedicated enable picks Timer 3 in variable modes and masks double-rate and Timer 2 selects in all modes.
// - Divider code in bits 2..0, codes 0..6; bits 6..3 ignore writes.
// - Timer 3 rate: twice core clock over 2^(code-1) times (fraction+64).
// - Mode bits decode to shift, variable 8, fixed 9, variable 9.
`timescale 1ns/1ns
module uart_baud_rate_generator (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Overflow pulse from Timer 1 when it runs in another mode
  input wire logic timer1Overflow,
  // Bit ticks to the shift logic
  output logic txBitTick,
  output logic rxBitTick
);
  import baud_pkg::*;

  // Registers
  logic [7:0] serialModeReg, power_control_reg, timer_mode_reg, timer1_reload_byte;
  logic [7:0] timer2_control_reg, timer2_reload_low, timer2_reload_high;
  logic [7:0] dedicated_bitrate_control, fractional_divider_value;
  logic [7:0] next_serialModeReg, next_power_control_reg, next_timer_mode_reg, next_timer1_reload_byte;
  logic [7:0] next_timer2_control_reg, next_timer2_reload_low, next_timer2_reload_high;
  logic [7:0] next_dedicated_bitrate_control, next_fractional_divider_value;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [7:0] regIndex;
  logic regWrite;
  logic [7:0] statusByte;
  assign regIndex = address[9:2];
  assign regWrite = write && !waitrequest && byteenable[0];
  always_comb
  begin
    next_serialModeReg = serialModeReg;
    next_power_control_reg = power_control_reg;
    next_timer_mode_reg = timer_mode_reg;
    next_timer1_reload_byte = timer1_reload_byte;
    next_timer2_control_reg = timer2_control_reg;
    next_timer2_reload_low = timer2_reload_low;
    next_timer2_reload_high = timer2_reload_high;
    next_dedicated_bitrate_control = dedicated_bitrate_control;
    next_fractional_divider_value = fractional_divider_value;
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    if (regWrite)
    begin
      case (regIndex)
        IDX_SERIAL_MODE: next_serialModeReg = writedata[7:0];
        IDX_POWER_CONTROL: next_power_control_reg = writedata[7:0];
        IDX_TIMER_MODE: next_timer_mode_reg = writedata[7:0];
        IDX_T1_RELOAD: next_timer1_reload_byte = writedata[7:0];
        IDX_T2_CONTROL: next_timer2_control_reg = writedata[7:0];
        IDX_T2_RELOAD_LOW: next_timer2_reload_low = writedata[7:0];
        IDX_T2_RELOAD_HIGH: next_timer2_reload_high = writedata[7:0];
        IDX_DEDICATED_CTRL:
        begin
          // Unimplemented bits stay zero; out-of-range codes clamp to the largest
          next_dedicated_bitrate_control = {writedata[DEDICATED_EN_BIT], 4'h0,
            (writedata[DIV_CODE_MSB:0] > DIV_CODE_MAX) ? DIV_CODE_MAX : writedata[DIV_CODE_MSB:0]};
        end
        IDX_FRACTIONAL_DIV: next_fractional_divider_value = {2'b00, writedata[FRAC_MSB:0]};
        default: ;
      endcase
    end
    if (read && waitrequest)
    begin
      case (regIndex)
        IDX_SERIAL_MODE: next_readdata = {24'h000000, serialModeReg};
        IDX_POWER_CONTROL: next_readdata = {24'h000000, power_control_reg};
        IDX_TIMER_MODE: next_readdata = {24'h000000, timer_mode_reg};
        IDX_T1_RELOAD: next_readdata = {24'h000000, timer1_reload_byte};
        IDX_T2_CONTROL: next_readdata = {24'h000000, timer2_control_reg};
        IDX_T2_RELOAD_LOW: next_readdata = {24'h000000, timer2_reload_low};
        IDX_T2_RELOAD_HIGH: next_readdata = {24'h000000, timer2_reload_high};
        IDX_STATUS: next_readdata = {24'h000000, statusByte};
        IDX_DEDICATED_CTRL: next_readdata = {24'h000000, dedicated_bitrate_control};
        IDX_FRACTIONAL_DIV: next_readdata = {24'h000000, fractional_divider_value};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      serialModeReg <= RESET_BYTE;
      power_control_reg <= RESET_BYTE;
      timer_mode_reg <= RESET_BYTE;
      timer1_reload_byte <= RESET_BYTE;
      timer2_control_reg <= RESET_BYTE;
      timer2_reload_low <= RESET_BYTE;
      timer2_reload_high <= RESET_BYTE;
      dedicated_bitrate_control <= RESET_BYTE;
      fractional_divider_value <= RESET_BYTE;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
    end
    else
    begin
      serialModeReg <= next_serialModeReg;
      power_control_reg <= next_power_control_reg;
      timer_mode_reg <= next_timer_mode_reg;
      timer1_reload_byte <= next_timer1_reload_byte;
      timer2_control_reg <= next_timer2_control_reg;
      timer2_reload_low <= next_timer2_reload_low;
      timer2_reload_high <= next_timer2_reload_high;
      dedicated_bitrate_control <= next_dedicated_bitrate_control;
      fractional_divider_value <= next_fractional_divider_value;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end
  // Configuration decode
  serial_mode_t serialMode;
  logic dedicatedTimerEnable, doubleRate, t2TxSelect, t2RxSelect, t2Baud, t1Auto, varMode;
  logic [2:0] divCode;
  always_comb
  begin
    case ({serialModeReg[SERIAL_MODE_A_BIT], serialModeReg[SERIAL_MODE_B_BIT]})
      2'b00: serialMode = MODE_SHIFT;
      2'b01: serialMode = MODE_VAR8;
      2'b10: serialMode = MODE_FIX9;
      2'b11: serialMode = MODE_VAR9;
      default: serialMode = MODE_SHIFT;
    endcase
  end
  assign dedicatedTimerEnable = dedicated_bitrate_control[DEDICATED_EN_BIT];
  assign divCode = dedicated_bitrate_control[DIV_CODE_MSB:0];
  // Dedicated timer masks the double-rate and Timer 2 select bits
  assign doubleRate = power_control_reg[DOUBLE_RATE_BIT] && !dedicatedTimerEnable;
  assign t2TxSelect = timer2_control_reg[T2_TX_SELECT_BIT] && !dedicatedTimerEnable;
  assign t2RxSelect = timer2_control_reg[T2_RX_SELECT_BIT] && !dedicatedTimerEnable;
  assign t2Baud = t2TxSelect || t2RxSelect;
  assign t1Auto = (timer_mode_reg[7:4] == T1_AUTORELOAD_NIBBLE);
  assign varMode = (serialMode == MODE_VAR8) || (serialMode == MODE_VAR9);
  assign statusByte = {serialMode, dedicatedTimerEnable, t2TxSelect, t2RxSelect, t1Auto};
  // Timer 1 as 8-bit autoreload counter at core clock
  logic [7:0] t1Count, next_t1Count;
  logic t1Ovf;
  always_comb
  begin
    next_t1Count = t1Count;
    if (t1Auto)
      next_t1Count = (t1Count == 8'hFF) ? timer1_reload_byte : t1Count + 8'h01;
  end
  assign t1Ovf = t1Auto ? (t1Count == 8'hFF) : timer1Overflow;
  // Timer 2 in generator mode: one step every two core clocks; idle, it holds the reload pair
  logic [15:0] t2Count, next_t2Count;
  logic t2Phase, next_t2Phase;
  logic t2Ovf;
  assign t2Ovf = t2Baud && t2Phase && (t2Count == 16'hFFFF);
  always_comb
  begin
    next_t2Count = t2Baud ? t2Count : {timer2_reload_high, timer2_reload_low};
    next_t2Phase = 1'b0;
    if (t2Baud)
    begin
      next_t2Phase = !t2Phase;
      if (t2Phase)
        next_t2Count = t2Ovf ? {timer2_reload_high, timer2_reload_low} : t2Count + 16'h0001;
    end
  end
  // Timer 3: binary prescaler then fractional divider giving a sixteen-times tick
  logic [5:0] t3Pre, next_t3Pre, t3Mask;
  logic [7:0] t3Acc, next_t3Acc, t3Sum, t3Limit;
  logic t3Tick16;
  assign t3Mask = 6'((7'h01 << divCode) - 7'h01);
  assign t3Sum = t3Acc + FRAC_OFFSET;
  assign t3Limit = fractional_divider_value + FRAC_OFFSET;
  always_comb
  begin
    next_t3Pre = t3Pre + 6'h01;
    next_t3Acc = t3Acc;
    t3Tick16 = 1'b0;
    if (!dedicatedTimerEnable)
    begin
      next_t3Pre = 6'h00;
      next_t3Acc = 8'h00;
    end
    else if ((t3Pre & t3Mask) == t3Mask)
    begin
      // Average tick rate is clock / 2^code * 64 / (fraction + 64)
      if (t3Sum >= t3Limit)
      begin
        next_t3Acc = t3Sum - t3Limit;
        t3Tick16 = 1'b1;
      end
      else
      begin
        next_t3Acc = t3Sum;
      end
    end
  end
  // Fixed and overflow dividers
  logic shiftTick, base16Tick, t1Div16, t2Bit, t3Bit;
  logic fixedHalf, next_fixedHalf, t1Half, next_t1Half;
  logic fixedBit, t1Bit;
  // Check helpers: cycles since the last register write, Timer 1 overflows since the last bit
  logic [7:0] quiet, next_quiet;
  logic [5:0] t1OvfSeen, next_t1OvfSeen;
  rate_divider #(.N(SHIFT_MODE_DIV)) u_shift_div (.ref_clk(ref_clk), .rst(rst), .en(1'b1), .tick(shiftTick));
  rate_divider #(.N(FIXED_BASE_DIV)) u_base_div (.ref_clk(ref_clk), .rst(rst), .en(1'b1), .tick(base16Tick));
  rate_divider #(.N(OVERFLOWS_PER_BIT)) u_t1_div (.ref_clk(ref_clk), .rst(rst), .en(t1Ovf), .tick(t1Div16));
  rate_divider #(.N(OVERFLOWS_PER_BIT)) u_t2_div (.ref_clk(ref_clk), .rst(rst), .en(t2Ovf), .tick(t2Bit));
  rate_divider #(.N(TICKS_PER_BIT)) u_t3_div (.ref_clk(ref_clk), .rst(rst), .en(t3Tick16), .tick(t3Bit));
  always_comb
  begin
    next_fixedHalf = base16Tick ? !fixedHalf : fixedHalf;
    next_t1Half = t1Div16 ? !t1Half : t1Half;
    next_quiet = regWrite ? 8'h00 : ((quiet == 8'hFF) ? quiet : quiet + 8'h01);
    next_t1OvfSeen = t1Bit ? 6'h00 : (t1Ovf ? t1OvfSeen + 6'h01 : t1OvfSeen);
  end
  // Double rate keeps every tick; otherwise every other one
  assign fixedBit = base16Tick && (doubleRate || fixedHalf);
  assign t1Bit = t1Div16 && (doubleRate || t1Half);
  // Per-direction source selection
  logic next_txBitTick, next_rxBitTick;
  always_comb
  begin
    next_txBitTick = 1'b0;
    next_rxBitTick = 1'b0;
    case (serialMode)
      MODE_SHIFT:
      begin
        next_txBitTick = shiftTick;
        next_rxBitTick = shiftTick;
      end
      MODE_FIX9:
      begin
        next_txBitTick = fixedBit;
        next_rxBitTick = fixedBit;
      end
      MODE_VAR8, MODE_VAR9:
      begin
        if (dedicatedTimerEnable)
        begin
          next_txBitTick = t3Bit;
          next_rxBitTick = t3Bit;
        end
        else
        begin
          next_txBitTick = t2TxSelect ? t2Bit : t1Bit;
          next_rxBitTick = t2RxSelect ? t2Bit : t1Bit;
        end
      end
      default: ;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      t1Count <= 8'h00;
      t2Count <= 16'h0000;
      t2Phase <= 1'b0;
      t3Pre <= 6'h00;
      t3Acc <= 8'h00;
      fixedHalf <= 1'b0;
      t1Half <= 1'b0;
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
      quiet <= 8'h00;
      t1OvfSeen <= 6'h00;
    end
    else
    begin
      t1Count <= next_t1Count;
      t2Count <= next_t2Count;
      t2Phase <= next_t2Phase;
      t3Pre <= next_t3Pre;
      t3Acc <= next_t3Acc;
      fixedHalf <= next_fixedHalf;
      t1Half <= next_t1Half;
      txBitTick <= next_txBitTick;
      rxBitTick <= next_rxBitTick;
      quiet <= next_quiet;
      t1OvfSeen <= next_t1OvfSeen;
    end
  end

  a_shift_period: assert property (@(posedge ref_clk) disable iff (rst)
    (txBitTick && serialMode == MODE_SHIFT && quiet > 8'd40) |-> ##12 (txBitTick || quiet < 8'd12))
    else $error("shift mode tick period not twelve");
  a_fixed_slow: assert property (@(posedge ref_clk) disable iff (rst)
    (txBitTick && serialMode == MODE_FIX9 && !doubleRate && quiet > 8'd80) |-> ##32 (txBitTick || quiet < 8'd32))
    else $error("fixed mode tick period not 32");
  a_fixed_fast: assert property (@(posedge ref_clk) disable iff (rst)
    (txBitTick && serialMode == MODE_FIX9 && doubleRate && quiet > 8'd40) |-> ##16 (txBitTick || quiet < 8'd16))
    else $error("fixed double-rate tick period not 16");
  a_t1_pacing: assert property (@(posedge ref_clk) disable iff (rst)
    (t1Bit && quiet == 8'hFF) |-> (t1OvfSeen == (doubleRate ? 6'd15 : 6'd31)))
    else $error("timer 1 bit tick not after 32 or 16 overflows");
  a_t2_halfstep: assert property (@(posedge ref_clk) disable iff (rst)
    (t2Baud && !t2Phase) |=> $stable(t2Count))
    else $error("timer 2 stepped on an off cycle");
  a_t2_reload: assert property (@(posedge ref_clk) disable iff (rst)
    t2Ovf |=> (t2Count == $past({timer2_reload_high, timer2_reload_low})))
    else $error("timer 2 did not reload from the pair");
  a_div_code: assert property (@(posedge ref_clk) disable iff (rst)
    (divCode <= DIV_CODE_MAX) && (dedicated_bitrate_control[6:3] == 4'h0))
    else $error("dedicated control holds an illegal field");
  a_t3_shared: assert property (@(posedge ref_clk) disable iff (rst)
    (t3Bit && dedicatedTimerEnable && varMode) |=> (txBitTick && rxBitTick))
    else $error("timer 3 tick not on both directions");
  a_t3_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    dedicatedTimerEnable |-> (!t2Baud && !doubleRate))
    else $error("masked select bits still active");
  a_bus_wait: assert property (@(posedge ref_clk) disable iff (rst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule

// ===== verification/tick_period_monitor.sv
// Behavioural stand-in for the serial shift logic: it takes the bit ticks and
// measures the spacing between them. It needs one-cycle ticks on ref_clk.
`timescale 1ns/1ns
module tick_period_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bit ticks from the generator
  input wire logic txBitTick,
  input wire logic rxBitTick,
  // Last measured spacing and running tick counts
  output logic [31:0] txPeriod,
  output logic [31:0] rxPeriod,
  output logic [31:0] txCount,
  output logic [31:0] rxCount
);
  logic [31:0] txAge;
  logic [31:0] rxAge;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      txAge <= 32'h0;
      rxAge <= 32'h0;
      txPeriod <= 32'h0;
      rxPeriod <= 32'h0;
      txCount <= 32'h0;
      rxCount <= 32'h0;
    end
    else
    begin
      txAge <= txBitTick ? 32'h1 : txAge + 32'h1;
      rxAge <= rxBitTick ? 32'h1 : rxAge + 32'h1;
      if (txBitTick)
      begin
        txPeriod <= txAge;
        txCount <= txCount + 32'h1;
      end
      if (rxBitTick)
      begin
        rxPeriod <= rxAge;
        rxCount <= rxCount + 32'h1;
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the bit-rate generator: register access over Avalon-MM,
// tick spacing measured by the shift-logic model. Assumes a 100 MHz ref_clk.
`timescale 1ns/1ns
module tb_top;
  import baud_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic timer1Overflow = 1'b0;
  logic txBitTick;
  logic rxBitTick;
  logic ovfRun = 1'b0;
  logic [1:0] ovfDiv = 2'h0;
  logic [31:0] txPeriod;
  logic [31:0] rxPeriod;
  logic [31:0] txCount;
  logic [31:0] rxCount;
  logic [31:0] rd;
  int fails = 0;
  int compares = 0;

  always #5 ref_clk = ~ref_clk;

  // External Timer 1 overflow: one pulse every third cycle
  always @(posedge ref_clk)
  begin
    ovfDiv <= (ovfDiv == 2'h2) ? 2'h0 : ovfDiv + 2'h1;
    timer1Overflow <= ovfRun && (ovfDiv == 2'h2);
  end

  uart_baud_rate_generator uut (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer1Overflow(timer1Overflow), .txBitTick(txBitTick), .rxBitTick(rxBitTick)
  );

  tick_period_monitor shift_model (
    .ref_clk(ref_clk), .rst(rst), .txBitTick(txBitTick), .rxBitTick(rxBitTick),
    .txPeriod(txPeriod), .rxPeriod(rxPeriod), .txCount(txCount), .rxCount(rxCount)
  );

  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] data, input logic [3:0] be);
    @(posedge ref_clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= ~wr;
    writedata <= {24'h0, data};
    byteenable <= be;
    do
    begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    bus(idx, 1'b1, data, 4'hF);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 8'h00, 4'hF);
    check(rd, exp);
  endtask

  // Lets the first, possibly short, bit pass and checks a clean spacing
  task automatic measure(input logic [31:0] expTx, input logic [31:0] expRx, input int limit);
    logic [31:0] t0;
    logic [31:0] r0;
    int n;
    t0 = txCount;
    r0 = rxCount;
    n = 0;
    while ((txCount < t0 + 32'h3 || rxCount < r0 + 32'h3) && n < limit)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= limit)
      fails++;
    check(txPeriod, expTx);
    check(rxPeriod, expRx);
  endtask

  initial
  begin
    // The tests need under 10,000 cycles; a hung bus wait ends here
    #300_000;
    fails++;
    final_report();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(IDX_DEDICATED_CTRL, 32'h0);
    rdchk(IDX_FRACTIONAL_DIV, 32'h0);
    rdchk(8'h50, 32'h0);
    measure(32'd12, 32'd12, 1000);
    $display("test reset_and_shift done");
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_SERIAL_MODE, 8'(i << 6));
      bus(IDX_STATUS, 1'b0, 8'h00, 4'hF);
      check({28'h0, rd[7:4]}, 32'(1 << i));
    end
    $display("test mode_decode done");
    wr(IDX_SERIAL_MODE, 8'h40);
    wr(IDX_TIMER_MODE, 8'h20);
    wr(IDX_T1_RELOAD, 8'hFF);
    wr(IDX_T2_RELOAD_LOW, 8'hFE);
    wr(IDX_T2_RELOAD_HIGH, 8'hFF);
    wr(IDX_T2_CONTROL, 8'h10);
    measure(32'd64, 32'd32, 5000);
    wr(IDX_T2_CONTROL, 8'h30);
    measure(32'd64, 32'd64, 5000);
    wr(IDX_T2_RELOAD_LOW, 8'hFC);
    measure(32'd128, 32'd128, 5000);
    $display("test timer2_source done");
    wr(IDX_T2_CONTROL, 8'h00);
    wr(IDX_T1_RELOAD, 8'hFE);
    measure(32'd64, 32'd64, 5000);
    wr(IDX_POWER_CONTROL, 8'h80);
    measure(32'd32, 32'd32, 5000);
    wr(IDX_POWER_CONTROL, 8'h00);
    wr(IDX_TIMER_MODE, 8'h10);
    ovfRun <= 1'b1;
    measure(32'd96, 32'd96, 5000);
    $display("test timer1_source done");
    wr(IDX_SERIAL_MODE, 8'h80);
    measure(32'd32, 32'd32, 5000);
    wr(IDX_POWER_CONTROL, 8'h80);
    measure(32'd16, 32'd16, 5000);
    wr(IDX_DEDICATED_CTRL, 8'h80);
    measure(32'd32, 32'd32, 5000);
    $display("test fixed_rate done");
    wr(IDX_SERIAL_MODE, 8'hC0);
    wr(IDX_T2_CONTROL, 8'h10);
    measure(32'd16, 32'd16, 5000);
    // Code and fraction chosen so that sixteen ticks span a whole number of cycles
    wr(IDX_DEDICATED_CTRL, 8'h82);
    wr(IDX_FRACTIONAL_DIV, 8'h2C);
    measure(32'd108, 32'd108, 5000);
    wr(IDX_FRACTIONAL_DIV, 8'h00);
    wr(IDX_DEDICATED_CTRL, 8'h81);
    measure(32'd32, 32'd32, 5000);
    $display("test timer3_source done");
    wr(IDX_DEDICATED_CTRL, 8'hFF);
    rdchk(IDX_DEDICATED_CTRL, 32'h86);
    wr(IDX_FRACTIONAL_DIV, 8'hFF);
    rdchk(IDX_FRACTIONAL_DIV, 32'h3F);
    bus(IDX_FRACTIONAL_DIV, 1'b1, 8'h00, 4'hE);
    rdchk(IDX_FRACTIONAL_DIV, 32'h3F);
    wr(8'h50, 8'h5A);
    rdchk(8'h50, 32'h0);
    wr(IDX_FRACTIONAL_DIV, 8'h00);
    measure(32'd1024, 32'd1024, 8000);
    $display("test register_fields done");
    final_report();
  end
endmodule
